// [rtl/psf_params.svh]
// register offsets, field positions, reset values and timing figures
`ifndef PSF_PARAMS_SVH
`define PSF_PARAMS_SVH
`define PSF_CLK_KHZ 25000
`define PSF_ADDR_SOFT_RESET_REQUEST 8'h01
`define PSF_ADDR_SLEEP 8'h02
`define PSF_ADDR_SHDN 8'h05
`define PSF_ADDR_SERIAL 8'h07
`define PSF_RST_SLEEP 8'h00
`define PSF_RST_SHDN 8'h05
`define PSF_RST_SERIAL 8'h30
`define PSF_SLP_WMASK 8'hfd
`define PSF_SHDN_WMASK 8'h3f
`define PSF_SWRST_BIT 0
`define PSF_SLP_SUPPLY_BIT 7
`define PSF_SLP_VREF_LSB 3
`define PSF_SLP_BCAST_BIT 2
`define PSF_SLP_EXIT_BIT 0
`define PSF_SHDN_INCAP_LSB 4
`define PSF_SHDN_POLICY_LSB 2
`define PSF_SHDN_HOLD_LSB 0
`define PSF_SER_FMT_LSB 6
`define PSF_SER_WLEN_LSB 4
`define PSF_SER_FSP_BIT 3
`define PSF_SER_BCP_BIT 2
`define PSF_SER_EDGE_BIT 1
`define PSF_SER_FILL_BIT 0
`define PSF_BCAST_ADDR 7'h4c
`define PSF_VREF0_US 3500
`define PSF_VREF1_US 10000
`define PSF_VREF2_US 50000
`define PSF_VREF3_US 100000
`define PSF_INCAP0_US 2500
`define PSF_INCAP1_US 12500
`define PSF_INCAP2_US 25000
`define PSF_INCAP3_US 50000
`define PSF_HOLD0_US 30000
`define PSF_HOLD1_US 25000
`define PSF_HOLD2_US 10000
`define PSF_HOLD3_US 5000
`endif

// [rtl/psf_pkg.sv]
// types shared by the power and serial format configuration block
package psf_pkg;
    typedef enum logic [1:0] {
        PSF_FMT_TDM = 2'h0,
        PSF_FMT_I2S = 2'h1,
        PSF_FMT_LJ = 2'h2,
        PSF_FMT_RSVD = 2'h3
    } psf_frame_fmt_t;

    typedef enum logic [1:0] {
        PSF_PD_IMMEDIATE = 2'h0,
        PSF_PD_TIMEOUT = 2'h1,
        PSF_PD_CLEAN = 2'h2,
        PSF_PD_RSVD = 2'h3
    } psf_pd_policy_t;

    typedef struct packed {
        psf_frame_fmt_t serialFrameFormat;
        logic [1:0] slotWordLength;
        logic frameSyncPolarity;
        logic bitClockPolarity;
        logic launchOnRising;
        logic idleFillHiZ;
    } psf_serial_cfg_t;

    typedef struct packed {
        logic analogSupplySourceSelect;
        logic [1:0] referencePrechargeTime;
        logic [1:0] inputCapPrechargeTime;
        logic sleepActive;
        logic [6:0] targetAddr;
    } psf_power_cfg_t;
endpackage

// [rtl/psf_core_hold.sv]
// core regulator keep-alive sequencer after the power-down pin asserts
`timescale 1ns/1ps
`default_nettype none
`include "psf_params.svh"
module psf_core_hold
    import psf_pkg::*;
#(
    parameter int CNT_W = 22,
    parameter int HOLD_CYC0 = `PSF_HOLD0_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC1 = `PSF_HOLD1_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC2 = `PSF_HOLD2_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC3 = `PSF_HOLD3_US * (`PSF_CLK_KHZ / 1000)
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic power_down_pin_n,
    input wire logic cleanShutdownDone,
    input wire psf_pd_policy_t power_down_policy,
    input wire logic [1:0] core_supply_hold_time,
    output logic coreRegulatorOn
);
    typedef enum logic [2:0] {
        PSF_CH_RUN = 3'b001,
        PSF_CH_HOLD = 3'b010,
        PSF_CH_OFF = 3'b100
    } psf_ch_state_t;

    psf_ch_state_t state_reg;
    psf_ch_state_t state_next;
    logic [CNT_W-1:0] count_reg;
    logic timed_reg;

    function automatic logic [CNT_W-1:0] holdCycles(input logic [1:0] code);
        case (code)
            2'h0: holdCycles = CNT_W'(HOLD_CYC0);
            2'h1: holdCycles = CNT_W'(HOLD_CYC1);
            2'h2: holdCycles = CNT_W'(HOLD_CYC2);
            default: holdCycles = CNT_W'(HOLD_CYC3);
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSF_CH_RUN: begin
                if (!power_down_pin_n) begin
                    // reserved policy treated as immediate, the safe choice
                    if (power_down_policy == PSF_PD_TIMEOUT
                            || power_down_policy == PSF_PD_CLEAN) begin
                        state_next = PSF_CH_HOLD;
                    end else begin
                        state_next = PSF_CH_OFF;
                    end
                end
            end
            PSF_CH_HOLD: begin
                if (power_down_pin_n) begin
                    state_next = PSF_CH_RUN;
                end else if (cleanShutdownDone) begin
                    state_next = PSF_CH_OFF;
                end else if (timed_reg && count_reg == '0) begin
                    state_next = PSF_CH_OFF;
                end
            end
            PSF_CH_OFF: begin
                if (power_down_pin_n) begin
                    state_next = PSF_CH_RUN;
                end
            end
            default: state_next = PSF_CH_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= PSF_CH_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // policy and hold time latched at the pin edge, later writes do not stretch it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            timed_reg <= 1'b0;
        end else if (state_reg == PSF_CH_RUN && state_next == PSF_CH_HOLD) begin
            count_reg <= holdCycles(core_supply_hold_time) - CNT_W'(1);
            timed_reg <= (power_down_policy == PSF_PD_TIMEOUT);
        end else if (state_reg == PSF_CH_HOLD && count_reg != '0) begin
            count_reg <= count_reg - CNT_W'(1);
        end
    end

    assign coreRegulatorOn = (state_reg != PSF_CH_OFF);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_immediate_off;
        state_reg == PSF_CH_RUN && !power_down_pin_n
            && power_down_policy == PSF_PD_IMMEDIATE |=> !coreRegulatorOn;
    endproperty
    a_immediate_off: assert property (p_immediate_off)
        else $error("core on after immediate off");

    sequence s_clean_wait;
        state_reg == PSF_CH_RUN && !power_down_pin_n && power_down_policy == PSF_PD_CLEAN;
    endsequence
    property p_clean_hold;
        s_clean_wait ##1 (!power_down_pin_n && !cleanShutdownDone)[*3] |-> coreRegulatorOn;
    endproperty
    a_clean_hold: assert property (p_clean_hold)
        else $error("core dropped before clean shutdown");

    property p_timeout_end;
        state_reg == PSF_CH_HOLD && timed_reg && count_reg == '0
            && !power_down_pin_n |=> !coreRegulatorOn;
    endproperty
    a_timeout_end: assert property (p_timeout_end) else $error("core not off at timeout");
endmodule
`default_nettype wire

// [rtl/psf_config_regs.sv]
// power, precharge, addressing and serial format configuration registers
// Overview of operation
// - sleep register bit 7: 0 external analog supply, 1 on-chip regulator.
// - sleep bits 4-3 pick reference precharge 3.5, 10, 50 or 100 ms.
// - broadcast bit 2 set: fixed target address 1001100, else fixed base with the two low bits from address pins.
// - sleep bit 0: 0 holds sleep, 1 exits; resets to 0.
// - shutdown bits 5-4 pick input capacitor precharge 2.5, 12.5, 25 or 50 ms.
// - shutdown bits 3-2: off at once, hold until timeout, until clean, reserved.
// - shutdown bits 1-0 pick core hold 30, 25, 10 or 5 ms.
// - shutdown register resets to 0x05; bits 7-6 read as zero.
// - serial bits 7-6 pick frame: TDM, I2S, left-justified, reserved.
// - serial bits 5-4 pick 16, 20, 24 or 32 bit slots; resets to 32.
// - bits 3 and 2 invert frame sync and bit clock; far end matches.
// - bit 1 moves data launch to the opposite bit clock edge.
// - bit 0: unused cycles drive zero, or high impedance when set.
// - soft reset write restores all registers to defaults, then self clears.
`timescale 1ns/1ps
`default_nettype none
`include "psf_params.svh"
module psf_config_regs
    import psf_pkg::*;
#(
    parameter int CNT_W = 22,
    parameter int CYC_PER_MS = `PSF_CLK_KHZ,
    parameter int VREF_CYC0 = (`PSF_VREF0_US * (`PSF_CLK_KHZ / 1000)),
    parameter int VREF_CYC1 = (`PSF_VREF1_US * (`PSF_CLK_KHZ / 1000)),
    parameter int VREF_CYC2 = (`PSF_VREF2_US * (`PSF_CLK_KHZ / 1000)),
    parameter int VREF_CYC3 = (`PSF_VREF3_US * (`PSF_CLK_KHZ / 1000)),
    parameter int INCAP_CYC0 = (`PSF_INCAP0_US * (`PSF_CLK_KHZ / 1000)),
    parameter int INCAP_CYC1 = (`PSF_INCAP1_US * (`PSF_CLK_KHZ / 1000)),
    parameter int INCAP_CYC2 = (`PSF_INCAP2_US * (`PSF_CLK_KHZ / 1000)),
    parameter int INCAP_CYC3 = (`PSF_INCAP3_US * (`PSF_CLK_KHZ / 1000)),
    parameter int HOLD_CYC0 = `PSF_HOLD0_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC1 = `PSF_HOLD1_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC2 = `PSF_HOLD2_US * (`PSF_CLK_KHZ / 1000),
    parameter int HOLD_CYC3 = `PSF_HOLD3_US * (`PSF_CLK_KHZ / 1000),
    parameter logic [4:0] PIN_ADDR_BASE = 5'h12
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [1:0] addrSelectPins,
    input wire logic power_down_pin_n,
    input wire logic cleanShutdownDone,
    output psf_power_cfg_t powerCfg,
    output psf_serial_cfg_t serialCfg,
    output logic [CNT_W-1:0] referencePrechargeCycles,
    output logic [CNT_W-1:0] inputCapPrechargeCycles,
    output logic coreRegulatorOn
);
    logic [7:0] sleep_reg;
    logic [7:0] shdn_reg;
    logic [7:0] serial_reg;
    logic softReset_reg;
    logic [7:0] rdData_reg;
    logic rdValid_reg;
    logic [7:0] rdData_next;
    logic regsInit;

    function automatic logic [CNT_W-1:0] pickCycles(input logic [1:0] code,
            input int c0, input int c1, input int c2, input int c3);
        case (code)
            2'h0: pickCycles = CNT_W'(c0);
            2'h1: pickCycles = CNT_W'(c1);
            2'h2: pickCycles = CNT_W'(c2);
            default: pickCycles = CNT_W'(c3);
        endcase
    endfunction

    function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
        hits = (a == target);
    endfunction

    // soft reset acts one edge after the write so the write itself completes
    assign regsInit = !rst_n || softReset_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            softReset_reg <= 1'b0;
        end else begin
            softReset_reg <= regWrEn && hits(regAddr, `PSF_ADDR_SOFT_RESET_REQUEST)
                && regWrData[`PSF_SWRST_BIT] && !softReset_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (regsInit) begin
            sleep_reg <= `PSF_RST_SLEEP;
        end else if (regWrEn && hits(regAddr, `PSF_ADDR_SLEEP)) begin
            sleep_reg <= regWrData & `PSF_SLP_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (regsInit) begin
            shdn_reg <= `PSF_RST_SHDN;
        end else if (regWrEn && hits(regAddr, `PSF_ADDR_SHDN)) begin
            shdn_reg <= regWrData & `PSF_SHDN_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (regsInit) begin
            serial_reg <= `PSF_RST_SERIAL;
        end else if (regWrEn && hits(regAddr, `PSF_ADDR_SERIAL)) begin
            serial_reg <= regWrData;
        end
    end

    // unmapped offsets and the self clearing reset bit read as zero
    always_comb begin
        rdData_next = 8'h00;
        case (regAddr)
            `PSF_ADDR_SLEEP: rdData_next = sleep_reg;
            `PSF_ADDR_SHDN: rdData_next = shdn_reg;
            `PSF_ADDR_SERIAL: rdData_next = serial_reg;
            default: rdData_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdData_reg <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= regRdEn;
            if (regRdEn) begin
                rdData_reg <= rdData_next;
            end
        end
    end

    assign regRdData = rdData_reg;
    assign regRdValid = rdValid_reg;

    always_comb begin
        powerCfg.analogSupplySourceSelect = sleep_reg[`PSF_SLP_SUPPLY_BIT];
        powerCfg.referencePrechargeTime = sleep_reg[`PSF_SLP_VREF_LSB +: 2];
        powerCfg.inputCapPrechargeTime = shdn_reg[`PSF_SHDN_INCAP_LSB +: 2];
        powerCfg.sleepActive = !sleep_reg[`PSF_SLP_EXIT_BIT];
        if (sleep_reg[`PSF_SLP_BCAST_BIT]) begin
            powerCfg.targetAddr = `PSF_BCAST_ADDR;
        end else begin
            powerCfg.targetAddr = {PIN_ADDR_BASE, addrSelectPins};
        end
    end

    always_comb begin
        serialCfg.serialFrameFormat = psf_frame_fmt_t'(serial_reg[`PSF_SER_FMT_LSB +: 2]);
        serialCfg.slotWordLength = serial_reg[`PSF_SER_WLEN_LSB +: 2];
        serialCfg.frameSyncPolarity = serial_reg[`PSF_SER_FSP_BIT];
        serialCfg.bitClockPolarity = serial_reg[`PSF_SER_BCP_BIT];
        // standard launch is the falling edge; the bit clock inversion and the edge bit each flip it
        serialCfg.launchOnRising = serial_reg[`PSF_SER_BCP_BIT]
            ^ serial_reg[`PSF_SER_EDGE_BIT];
        serialCfg.idleFillHiZ = serial_reg[`PSF_SER_FILL_BIT];
    end

    assign referencePrechargeCycles = pickCycles(powerCfg.referencePrechargeTime,
        VREF_CYC0, VREF_CYC1, VREF_CYC2, VREF_CYC3);
    assign inputCapPrechargeCycles = pickCycles(powerCfg.inputCapPrechargeTime,
        INCAP_CYC0, INCAP_CYC1, INCAP_CYC2, INCAP_CYC3);

    psf_core_hold #(
        .CNT_W(CNT_W),
        .HOLD_CYC0(HOLD_CYC0),
        .HOLD_CYC1(HOLD_CYC1),
        .HOLD_CYC2(HOLD_CYC2),
        .HOLD_CYC3(HOLD_CYC3)
    ) u_core_hold (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .power_down_pin_n(power_down_pin_n),
        .cleanShutdownDone(cleanShutdownDone),
        .power_down_policy(psf_pd_policy_t'(shdn_reg[`PSF_SHDN_POLICY_LSB +: 2])),
        .core_supply_hold_time(shdn_reg[`PSF_SHDN_HOLD_LSB +: 2]),
        .coreRegulatorOn(coreRegulatorOn)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_soft_reset_write;
        regWrEn && regAddr == `PSF_ADDR_SOFT_RESET_REQUEST && regWrData[`PSF_SWRST_BIT]
            && !softReset_reg;
    endsequence
    property p_soft_reset_defaults;
        s_soft_reset_write ##1 1'b1 |=> sleep_reg == 8'h00 && shdn_reg == 8'h05
            && serial_reg == 8'h30;
    endproperty
    a_soft_reset_defaults: assert property (p_soft_reset_defaults)
        else $error("soft reset left a register");

    property p_soft_reset_clears;
        s_soft_reset_write |=> softReset_reg ##1 !softReset_reg;
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears)
        else $error("soft reset bit did not self clear");

    property p_shdn_reserved_zero;
        regRdEn && regAddr == `PSF_ADDR_SHDN |=> regRdValid && regRdData[7:6] == 2'h0;
    endproperty
    a_shdn_reserved_zero: assert property (p_shdn_reserved_zero)
        else $error("reserved shutdown bits not zero");

    property p_sleep_bit1_zero;
        regRdEn && regAddr == `PSF_ADDR_SLEEP |=> regRdData[1] == 1'b0;
    endproperty
    a_sleep_bit1_zero: assert property (p_sleep_bit1_zero)
        else $error("read-only sleep bit not zero");

    property p_serial_write;
        regWrEn && regAddr == `PSF_ADDR_SERIAL && !softReset_reg
            |=> serial_reg == $past(regWrData);
    endproperty
    a_serial_write: assert property (p_serial_write)
        else $error("serial format write lost");

    property p_sleep_follows;
        regWrEn && regAddr == `PSF_ADDR_SLEEP && !softReset_reg
            |=> powerCfg.sleepActive == !$past(regWrData[0]);
    endproperty
    a_sleep_follows: assert property (p_sleep_follows)
        else $error("sleep state wrong after write");

    property p_broadcast_addr;
        sleep_reg[`PSF_SLP_BCAST_BIT] |-> powerCfg.targetAddr == 7'h4c;
    endproperty
    a_broadcast_addr: assert property (p_broadcast_addr)
        else $error("broadcast address wrong");

    property p_launch_edge;
        serialCfg.launchOnRising == (serial_reg[2] != serial_reg[1]);
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("launch edge wrong");

    // a write in the soft reset cycle is lost, so it is left out here
    sequence s_sleep_write;
        regWrEn && regAddr == `PSF_ADDR_SLEEP && !softReset_reg;
    endsequence

    sequence s_shdn_write;
        regWrEn && regAddr == `PSF_ADDR_SHDN && !softReset_reg;
    endsequence

    sequence s_serial_write;
        regWrEn && regAddr == `PSF_ADDR_SERIAL && !softReset_reg;
    endsequence

    property p_supply_select;
        s_sleep_write |=> powerCfg.analogSupplySourceSelect == $past(regWrData[7]);
    endproperty
    a_supply_select: assert property (p_supply_select)
        else $error("supply select not stored");

    property p_vref_field;
        s_sleep_write |=> powerCfg.referencePrechargeTime == $past(regWrData[4:3]);
    endproperty
    a_vref_field: assert property (p_vref_field)
        else $error("reference precharge code not stored");

    property p_vref_longest;
        powerCfg.referencePrechargeTime == 2'h3
            |-> referencePrechargeCycles == CNT_W'(VREF_CYC3);
    endproperty
    a_vref_longest: assert property (p_vref_longest)
        else $error("longest reference precharge count wrong");

    property p_pin_addr;
        !sleep_reg[`PSF_SLP_BCAST_BIT] |-> powerCfg.targetAddr[1:0] == addrSelectPins;
    endproperty
    a_pin_addr: assert property (p_pin_addr)
        else $error("target address ignores the pins");

    property p_incap_field;
        s_shdn_write |=> powerCfg.inputCapPrechargeTime == $past(regWrData[5:4]);
    endproperty
    a_incap_field: assert property (p_incap_field)
        else $error("input precharge code not stored");

    property p_shdn_store;
        s_shdn_write |=> shdn_reg == ($past(regWrData) & 8'h3f);
    endproperty
    a_shdn_store: assert property (p_shdn_store)
        else $error("shutdown write not stored as masked");

    property p_serial_fields;
        s_serial_write |=> serialCfg.serialFrameFormat == $past(regWrData[7:6])
            && serialCfg.slotWordLength == $past(regWrData[5:4]);
    endproperty
    a_serial_fields: assert property (p_serial_fields)
        else $error("frame format or slot length wrong");

    property p_polarity;
        s_serial_write |=> serialCfg.frameSyncPolarity == $past(regWrData[3])
            && serialCfg.bitClockPolarity == $past(regWrData[2]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity bits wrong");

    property p_idle_fill;
        s_serial_write |=> serialCfg.idleFillHiZ == $past(regWrData[0]);
    endproperty
    a_idle_fill: assert property (p_idle_fill)
        else $error("idle fill bit wrong");

    property p_unmapped_zero;
        regRdEn && regAddr != `PSF_ADDR_SLEEP && regAddr != `PSF_ADDR_SHDN
            && regAddr != `PSF_ADDR_SERIAL |=> regRdValid && regRdData == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped offset read not zero");
endmodule
`default_nettype wire

// [bench/psf_host_model.sv]
// control bus host model issuing single-byte register strobes
`timescale 1ns/1ps
`default_nettype none
module psf_host_model (
    input wire logic sys_clk,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    // idle address and data are scrambled so nothing leans on stale values
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = ~addr;
        regWrData = ~data;
    endtask

    // read answer is registered, so it is taken one cycle after the strobe
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data,
        output logic valid);
        @(negedge sys_clk);
        regAddr = addr;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        valid = regRdValid;
        data = regRdData;
        regRdEn = 1'b0;
        regAddr = ~addr;
    endtask
endmodule
`default_nettype wire

// [bench/psf_config_regs_tb_top.sv]
// self-checking bench for the power and serial format register block
`timescale 1ns/1ps
`default_nettype none
`include "psf_params.svh"
module psf_config_regs_tb_top
    import psf_pkg::*;
;
    // short counts keep the run small; expectations use these tables
    localparam int HOLD [4] = '{30, 25, 10, 5};
    localparam int VREF [4] = '{7, 20, 100, 200};
    localparam int INCAP [4] = '{5, 25, 50, 100};
    localparam logic [4:0] PIN_BASE = 5'h12;
    localparam logic [7:0] SER_VALS [5] = '{8'h0f, 8'h5a, 8'ha5, 8'hf0, 8'h36};
    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWrEn;
    logic regRdEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [1:0] addrSelectPins = 2'h0;
    logic pwrDownPinN = 1'b1;
    logic cleanShutdownDone = 1'b0;
    psf_power_cfg_t powerCfg;
    psf_serial_cfg_t serialCfg;
    psf_serial_cfg_t expSer;
    logic [21:0] refCycles;
    logic [21:0] incapCycles;
    logic coreRegulatorOn;
    int nErrors = 0;
    int checksDone = 0;
    int cycleCount = 0;

    always #20 sys_clk = ~sys_clk;

    psf_host_model u_psf_host_model (
        .sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
    );

    psf_config_regs #(
        .CNT_W(22), .CYC_PER_MS(`PSF_CLK_KHZ),
        .VREF_CYC0(VREF[0]), .VREF_CYC1(VREF[1]), .VREF_CYC2(VREF[2]), .VREF_CYC3(VREF[3]),
        .INCAP_CYC0(INCAP[0]), .INCAP_CYC1(INCAP[1]), .INCAP_CYC2(INCAP[2]),
        .INCAP_CYC3(INCAP[3]), .HOLD_CYC0(HOLD[0]), .HOLD_CYC1(HOLD[1]),
        .HOLD_CYC2(HOLD[2]), .HOLD_CYC3(HOLD[3]), .PIN_ADDR_BASE(PIN_BASE)
    ) u_psf_config_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .addrSelectPins(addrSelectPins),
        .power_down_pin_n(pwrDownPinN), .cleanShutdownDone(cleanShutdownDone),
        .powerCfg(powerCfg), .serialCfg(serialCfg), .referencePrechargeCycles(refCycles),
        .inputCapPrechargeCycles(incapCycles), .coreRegulatorOn(coreRegulatorOn)
    );

    task automatic giveVerdict();
        $display("checks done %0d, errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic checkValue(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_psf_host_model.writeReg(addr, data);
    endtask

    task automatic rdCheck(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic valid;
        u_psf_host_model.readReg(addr, data, valid);
        checkValue({31'h0, valid}, 32'h1);
        checkValue({24'h0, data}, {24'h0, exp});
    endtask

    // counts falling edges from pin assertion, or from clean done under the clean policy, until the core supply drops
    task automatic pdCount(input logic [7:0] shdnVal, input int expCyc);
        int n;
        wr(`PSF_ADDR_SHDN, shdnVal);
        @(negedge sys_clk);
        pwrDownPinN = 1'b0;
        if (shdnVal[3:2] == 2'h2) begin
            repeat (40) @(negedge sys_clk);
            checkValue({31'h0, coreRegulatorOn}, 32'h1);
            cleanShutdownDone = 1'b1;
        end
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (coreRegulatorOn !== 1'b0 && n < 200);
        checkValue(n, expCyc);
        pwrDownPinN = 1'b1;
        cleanShutdownDone = 1'b0;
        @(negedge sys_clk);
        checkValue({31'h0, coreRegulatorOn}, 32'h1);
    endtask

    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount >= LIMIT) begin
            nErrors++;
            giveVerdict();
        end
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        checkValue({31'h0, powerCfg.sleepActive}, 32'h1);
        checkValue({31'h0, coreRegulatorOn}, 32'h1);
        rdCheck(`PSF_ADDR_SLEEP, 8'h00);
        rdCheck(`PSF_ADDR_SHDN, 8'h05);
        rdCheck(`PSF_ADDR_SERIAL, 8'h30);
        rdCheck(`PSF_ADDR_SOFT_RESET_REQUEST, 8'h00);
        wr(`PSF_ADDR_SLEEP, 8'hff);
        rdCheck(`PSF_ADDR_SLEEP, 8'hfd);
        checkValue({31'h0, powerCfg.analogSupplySourceSelect}, 32'h1);
        checkValue({31'h0, powerCfg.sleepActive}, 32'h0);
        checkValue({25'h0, powerCfg.targetAddr}, 32'h4c);
        wr(`PSF_ADDR_SLEEP, 8'h60);
        rdCheck(`PSF_ADDR_SLEEP, 8'h60);
        checkValue({31'h0, powerCfg.analogSupplySourceSelect}, 32'h0);
        checkValue({31'h0, powerCfg.sleepActive}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            addrSelectPins = i[1:0];
            wr(`PSF_ADDR_SLEEP, {3'h0, i[1:0], 3'h1});
            checkValue({10'h0, refCycles}, VREF[i]);
            checkValue({25'h0, powerCfg.targetAddr}, {25'h0, PIN_BASE, i[1:0]});
            wr(`PSF_ADDR_SHDN, {2'h3, i[1:0], 4'h5});
            checkValue({10'h0, incapCycles}, INCAP[i]);
            rdCheck(`PSF_ADDR_SHDN, {2'h0, i[1:0], 4'h5});
        end
        for (int i = 0; i < 5; i++) begin
            wr(`PSF_ADDR_SERIAL, SER_VALS[i]);
            expSer = psf_serial_cfg_t'(SER_VALS[i]);
            expSer.launchOnRising = SER_VALS[i][2] ^ SER_VALS[i][1];
            checkValue({24'h0, serialCfg}, {24'h0, expSer});
            rdCheck(`PSF_ADDR_SERIAL, SER_VALS[i]);
        end
        wr(8'h03, 8'hff);
        rdCheck(8'h03, 8'h00);
        wr(`PSF_ADDR_SLEEP, 8'h9d);
        wr(`PSF_ADDR_SOFT_RESET_REQUEST, 8'h01);
        repeat (2) @(negedge sys_clk);
        rdCheck(`PSF_ADDR_SLEEP, 8'h00);
        rdCheck(`PSF_ADDR_SHDN, 8'h05);
        rdCheck(`PSF_ADDR_SERIAL, 8'h30);
        rdCheck(`PSF_ADDR_SOFT_RESET_REQUEST, 8'h00);
        checkValue({31'h0, powerCfg.sleepActive}, 32'h1);
        pdCount(8'h00, 1);
        pdCount(8'h0c, 1);
        for (int h = 0; h < 4; h++) begin
            pdCount({6'h01, h[1:0]}, HOLD[h] + 1);
        end
        pdCount(8'h08, 1);
        giveVerdict();
    end
endmodule
`default_nettype wire
